// File: bher_params.svh
// Constants for the beacon hard-error recovery block: codes, counts and timing
`ifndef BHER_PARAMS_SVH
`define BHER_PARAMS_SVH

// System clock rate in hertz
`define BHER_CLK_HZ        64'd250000000
// Contention watchdog time in seconds
`define BHER_CONT_S        64'd1
// Silence allowed in beacon repeat, in milliseconds
`define BHER_BRPT_MS       64'd200
// Self-removal time in beacon transmit, in seconds
`define BHER_BTX_S         64'd26
// Derived cycle counts
`define BHER_CONT_CYC      (`BHER_CONT_S * `BHER_CLK_HZ)
`define BHER_BRPT_CYC      ((`BHER_BRPT_MS * `BHER_CLK_HZ) / 64'd1000)
`define BHER_BTX_CYC       (`BHER_BTX_S * `BHER_CLK_HZ)
// Half-bit run lengths without phase change
`define BHER_BURST4_HB     8'd4
`define BHER_BURST5_HB     8'd5
`define BHER_SIGLOSS_HB    8'd32
// Beacon type codes
`define BHER_CODE_SIGLOSS  16'h0002
`define BHER_CODE_STREAM   16'h0003
`define BHER_CODE_CLAIM    16'h0004
// Field widths
`define BHER_TMR_W         34
`define BHER_ADDR_W        48

`endif

// File: bher_pkg.sv
// Types for the beacon hard-error recovery block
package bher_pkg;
    // Recovery modes of the station
    typedef enum logic [2:0] {
        BHER_NORMAL,
        BHER_CONT_RPT,
        BHER_CONT_TX,
        BHER_BCN_TX,
        BHER_BCN_RPT,
        BHER_REMOVE,
        BHER_CLOSED
    } bher_mode_t;
endpackage

// File: bher_recovery.sv
// Hard-error recovery controller: burst detection, contention, beaconing and removal
`timescale 1ns/1ps
`include "bher_params.svh"

module bher_recovery #(
    parameter logic [`BHER_TMR_W-1:0] CONT_CYC = `BHER_TMR_W'(`BHER_CONT_CYC),
    parameter logic [`BHER_TMR_W-1:0] BRPT_CYC = `BHER_TMR_W'(`BHER_BRPT_CYC),
    parameter logic [`BHER_TMR_W-1:0] BTX_CYC  = `BHER_TMR_W'(`BHER_BTX_CYC)
) (
    input  wire logic                    CLK_SYS,         // System clock
    input  wire logic                    ARST_N,          // Asynchronous reset, low
    input  wire logic                    RING_CLK,        // Recovered ring clock pin
    input  wire logic                    RING_DATA,       // Received ring half-bit data pin
    input  wire logic                    CLAIM_RX,        // Claim-token frame received
    input  wire logic                    PURGE_RX,        // Ring purge frame received
    input  wire logic                    BCN_RX,          // Foreign beacon frame received
    input  wire logic                    BCN_RX_OWN,      // Own beacon frame returned
    input  wire logic [15:0]             BCN_RX_CODE,     // Code of received beacon
    input  wire logic                    BCN_RX_NAMES_ME, // Received beacon names us upstream
    input  wire logic                    STREAM_ERR,      // Streaming-data error detected
    input  wire logic                    CLAIM_STREAM,    // Claim-token streaming detected
    input  wire logic                    CONT_START,      // Other cause starts contention
    input  wire logic                    CONT_WON,        // Contention resolved
    input  wire logic                    TEST_DONE,       // Self test finished
    input  wire logic                    TEST_PASS,       // Self test result
    input  wire logic [`BHER_ADDR_W-1:0] UPSTREAM_NEIGHBOUR_ADDR, // Stored neighbour address
    output logic                         TX_IDLE,         // Transmit idles instead of repeat
    output logic                         BURST5,          // Burst-5 condition flag
    output logic                         SIG_LOSS,        // Signal-loss condition flag
    output logic                         PURGE_ACT,       // Purge frame to be acted on
    output bher_pkg::bher_mode_t         MODE,            // Current recovery mode
    output logic                         BCN_SEND,        // Keep sending beacon frames
    output logic [15:0]                  BCN_CODE,        // Beacon type code to send
    output logic [`BHER_ADDR_W-1:0]      BCN_UNA,         // Neighbour address in beacon
    output logic                         INSERTED,        // Station inserted in ring
    output logic                         TEST_RUN,        // Self test requested
    output logic                         REMOVED_RPT      // Removal reported to host
);

    // Ring pin synchronisers and half-bit run tracking
    logic       rclk_s1, rclk_s2, rclk_s3;   // Ring clock sync chain plus edge stage
    logic       rdat_s1, rdat_s2;            // Ring data sync chain
    logic       last_bit, next_last_bit;     // Previous half-bit level
    logic [7:0] run, next_run;               // Half-bits without phase change
    logic       hb_stb;                      // Half-bit strobe on either clock edge

    // Recovery state
    bher_pkg::bher_mode_t      next_mode;    // Next recovery mode
    logic [`BHER_TMR_W-1:0]    tmr, next_tmr;          // Shared mode timer
    logic                      claim_seen, next_claim_seen; // Claim frames seen this episode
    logic                      loss_cause, next_loss_cause; // Contention began on signal loss
    logic [15:0]               next_code;              // Next beacon code
    logic [`BHER_ADDR_W-1:0]   next_una;               // Next beacon neighbour address
    logic                      next_removed;           // Next removal report
    logic                      tmr_end;                // Mode timer expired
    logic                      sig_loss_now;           // Live signal-loss condition

    // Timer limit for the mode in force
    function automatic logic [`BHER_TMR_W-1:0] limit_of(input bher_pkg::bher_mode_t m);
        case (m)
            bher_pkg::BHER_CONT_RPT, bher_pkg::BHER_CONT_TX: limit_of = CONT_CYC;
            bher_pkg::BHER_BCN_RPT:                          limit_of = BRPT_CYC;
            bher_pkg::BHER_BCN_TX:                           limit_of = BTX_CYC;
            default:                                         limit_of = '1;
        endcase
    endfunction

    // Ring half-bit run counter, next values
    always_comb begin
        hb_stb        = rclk_s2 ^ rclk_s3;
        next_last_bit = last_bit;
        next_run      = run;
        if (hb_stb) begin
            next_last_bit = rdat_s2;
            if (rdat_s2 != last_bit) begin
                next_run = 8'h01;
            end else if (run != 8'hFF) begin
                next_run = run + 8'h01;
            end
        end
    end

    // Ring synchronisers and run counter registers
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rclk_s1  <= 1'b0;
            rclk_s2  <= 1'b0;
            rclk_s3  <= 1'b0;
            rdat_s1  <= 1'b0;
            rdat_s2  <= 1'b0;
            last_bit <= 1'b0;
            run      <= 8'h00;
            TX_IDLE  <= 1'b0;
            BURST5   <= 1'b0;
            SIG_LOSS <= 1'b0;
        end else begin
            rclk_s1  <= RING_CLK;
            rclk_s2  <= rclk_s1;
            rclk_s3  <= rclk_s2;
            rdat_s1  <= RING_DATA;
            rdat_s2  <= rdat_s1;
            last_bit <= next_last_bit;
            run      <= next_run;
            TX_IDLE  <= (next_run >= `BHER_BURST4_HB);
            BURST5   <= (next_run >= `BHER_BURST5_HB);
            SIG_LOSS <= (next_run >= `BHER_SIGLOSS_HB);
        end
    end

    assign sig_loss_now = SIG_LOSS;
    assign tmr_end      = (tmr >= limit_of(MODE) - `BHER_TMR_W'(1));
    // Contention transmitter drops purge frames
    assign PURGE_ACT    = PURGE_RX && (MODE != bher_pkg::BHER_CONT_TX);
    assign BCN_SEND     = (MODE == bher_pkg::BHER_BCN_TX);
    assign INSERTED     = (MODE != bher_pkg::BHER_REMOVE) && (MODE != bher_pkg::BHER_CLOSED);
    assign TEST_RUN     = (MODE == bher_pkg::BHER_REMOVE);

    // Recovery mode transitions, next values
    always_comb begin
        next_mode       = MODE;
        next_code       = BCN_CODE;
        next_una        = BCN_UNA;
        next_removed    = REMOVED_RPT;
        next_claim_seen = claim_seen | CLAIM_RX;   // Set wins over any clear below
        next_loss_cause = loss_cause;
        next_tmr        = tmr + `BHER_TMR_W'(1);
        case (MODE)
            bher_pkg::BHER_NORMAL: begin
                next_claim_seen = CLAIM_RX;
                next_loss_cause = 1'b0;
                if (sig_loss_now) begin
                    next_mode       = bher_pkg::BHER_CONT_TX;
                    next_loss_cause = 1'b1;
                end else if (CONT_START) begin
                    next_mode = bher_pkg::BHER_CONT_TX;
                end else if (CLAIM_RX) begin
                    next_mode = bher_pkg::BHER_CONT_RPT;
                end
            end
            bher_pkg::BHER_CONT_RPT, bher_pkg::BHER_CONT_TX: begin
                if (BCN_RX) begin
                    next_mode = bher_pkg::BHER_BCN_RPT;
                end else if (CONT_WON) begin
                    next_mode = bher_pkg::BHER_NORMAL;
                end else if (tmr_end) begin
                    next_mode = bher_pkg::BHER_BCN_TX;
                    next_una  = UPSTREAM_NEIGHBOUR_ADDR;
                    if (loss_cause) begin
                        next_code = `BHER_CODE_SIGLOSS;
                    end else if (next_claim_seen) begin
                        next_code = `BHER_CODE_CLAIM;
                    end else begin
                        next_code = `BHER_CODE_STREAM;
                    end
                end
            end
            bher_pkg::BHER_BCN_TX: begin
                if (BCN_RX_OWN) begin
                    next_mode       = bher_pkg::BHER_CONT_TX;
                    next_loss_cause = 1'b0;
                end else if (BCN_RX && (BCN_RX_CODE <= BCN_CODE)) begin
                    next_mode = bher_pkg::BHER_BCN_RPT;
                end else if (tmr_end) begin
                    next_mode = bher_pkg::BHER_REMOVE;
                end
            end
            bher_pkg::BHER_BCN_RPT: begin
                if (BCN_RX) begin
                    next_tmr = '0;
                end else if (tmr_end) begin
                    next_mode       = bher_pkg::BHER_CONT_TX;
                    next_loss_cause = 1'b0;
                end
            end
            bher_pkg::BHER_REMOVE: begin
                if (TEST_DONE && TEST_PASS) begin
                    next_mode = bher_pkg::BHER_NORMAL;
                end else if (TEST_DONE) begin
                    next_mode    = bher_pkg::BHER_CLOSED;
                    next_removed = 1'b1;
                end
            end
            bher_pkg::BHER_CLOSED: begin
                next_mode = bher_pkg::BHER_CLOSED;              // Off-ring until reset
            end
            default: begin
                next_mode = bher_pkg::BHER_NORMAL;
            end
        endcase
        // Streaming conditions override contention and normal modes
        if ((MODE == bher_pkg::BHER_NORMAL) || (MODE == bher_pkg::BHER_CONT_RPT)
            || (MODE == bher_pkg::BHER_CONT_TX)) begin
            if (STREAM_ERR) begin
                next_mode = bher_pkg::BHER_BCN_TX;
                next_code = `BHER_CODE_STREAM;
                next_una  = UPSTREAM_NEIGHBOUR_ADDR;
            end else if (CLAIM_STREAM) begin
                next_mode = bher_pkg::BHER_BCN_TX;
                next_code = `BHER_CODE_CLAIM;
                next_una  = UPSTREAM_NEIGHBOUR_ADDR;
            end
        end
        // Named upstream neighbour leaves the ring for its self test
        if (BCN_RX && BCN_RX_NAMES_ME && INSERTED) begin
            next_mode = bher_pkg::BHER_REMOVE;
        end
        if (next_mode != MODE) begin
            next_tmr = '0;
        end
    end

    // Recovery state registers
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            MODE        <= bher_pkg::BHER_NORMAL;
            tmr         <= '0;
            claim_seen  <= 1'b0;
            loss_cause  <= 1'b0;
            BCN_CODE    <= 16'h0000;
            BCN_UNA     <= '0;
            REMOVED_RPT <= 1'b0;
        end else begin
            MODE        <= next_mode;
            tmr         <= next_tmr;
            claim_seen  <= next_claim_seen;
            loss_cause  <= next_loss_cause;
            BCN_CODE    <= next_code;
            BCN_UNA     <= next_una;
            REMOVED_RPT <= next_removed;
        end
    end

    // Checks on the recovery behaviour
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    chk_idle_on_burst: assert property ((hb_stb && (rdat_s2 == last_bit)
        && (run >= `BHER_BURST4_HB - 8'h01)) |=> TX_IDLE)
        else $error("idles not sent on burst-4");
    chk_burst5_flag: assert property ($rose(BURST5) |-> $past(next_run) == `BHER_BURST5_HB)
        else $error("burst-5 flag at wrong run length");
    chk_loss_to_cont: assert property ((MODE == bher_pkg::BHER_NORMAL && SIG_LOSS && !STREAM_ERR
        && !CLAIM_STREAM && !BCN_RX) |=> MODE == bher_pkg::BHER_CONT_TX)
        else $error("signal loss did not start contention");
    chk_loss_code: assert property ((MODE == bher_pkg::BHER_CONT_TX && loss_cause && tmr_end
        && !BCN_RX && !CONT_WON && !STREAM_ERR && !CLAIM_STREAM)
        |=> MODE == bher_pkg::BHER_BCN_TX && BCN_CODE == `BHER_CODE_SIGLOSS)
        else $error("signal loss beacon code wrong");
    chk_cont_bound: assert property ((MODE inside {bher_pkg::BHER_CONT_RPT, bher_pkg::BHER_CONT_TX})
        |-> tmr < CONT_CYC)
        else $error("contention outlived its watchdog");
    chk_lower_beacon: assert property ((MODE == bher_pkg::BHER_BCN_TX && BCN_RX && !BCN_RX_OWN
        && BCN_RX_CODE <= BCN_CODE && !BCN_RX_NAMES_ME) |=> MODE == bher_pkg::BHER_BCN_RPT)
        else $error("beacon transmitter did not yield");
    chk_own_beacon: assert property ((MODE == bher_pkg::BHER_BCN_TX && BCN_RX_OWN
        && !(BCN_RX && BCN_RX_NAMES_ME)) |=> MODE == bher_pkg::BHER_CONT_TX)
        else $error("own beacon did not restart contention");
    chk_repeat_quiet: assert property ((MODE == bher_pkg::BHER_BCN_RPT) |-> tmr < BRPT_CYC)
        else $error("beacon repeat outlived silence limit");
    chk_tx_removal: assert property ((MODE == bher_pkg::BHER_BCN_TX) |-> tmr < BTX_CYC)
        else $error("beacon transmit outlived removal time");
    chk_stream_code: assert property ((MODE == bher_pkg::BHER_NORMAL && STREAM_ERR
        && !(BCN_RX && BCN_RX_NAMES_ME)) |=> MODE == bher_pkg::BHER_BCN_TX
        && BCN_CODE == `BHER_CODE_STREAM && BCN_UNA == $past(UPSTREAM_NEIGHBOUR_ADDR))
        else $error("streaming beacon wrong");
    chk_purge_ignored: assert property ((MODE == bher_pkg::BHER_CONT_TX) |-> !PURGE_ACT)
        else $error("purge acted on in contention transmit");
    chk_test_fail: assert property ((MODE == bher_pkg::BHER_REMOVE && TEST_DONE && !TEST_PASS)
        |=> MODE == bher_pkg::BHER_CLOSED && REMOVED_RPT && !INSERTED)
        else $error("failed test did not close station");

    cov_beacon_tx: cover property (MODE == bher_pkg::BHER_CONT_TX ##1 MODE == bher_pkg::BHER_BCN_TX);
    cov_beacon_rpt: cover property (MODE == bher_pkg::BHER_BCN_TX ##1 MODE == bher_pkg::BHER_BCN_RPT);
    cov_recovered: cover property (MODE == bher_pkg::BHER_BCN_TX ##1 MODE == bher_pkg::BHER_CONT_TX);
    cov_closed: cover property (MODE == bher_pkg::BHER_REMOVE ##1 MODE == bher_pkg::BHER_CLOSED);

endmodule

// File: bher_ring_model.sv
// Behavioural model of the upstream ring: half-bit clock and Manchester data
`timescale 1ns/1ps

module bher_ring_model (
    input  wire logic run,       // Ring clock runs while a frame is on the line
    input  wire logic stuck,     // Data stops changing phase (broken or silent ring)
    output logic      ring_clk,  // Recovered ring clock, 32 ns period
    output logic      ring_data  // Received half-bit level
);
    // Data moves mid half-bit so the block never samples it on a changing level;
    // with the clock stopped the line keeps toggling rather than holding a stale value
    initial begin
        ring_clk  = 1'b0;
        ring_data = 1'b0;
        forever begin
            #8;
            if (!stuck) begin
                ring_data = ~ring_data;
            end
            #8;
            if (run) begin
                ring_clk = ~ring_clk;
            end
        end
    end
endmodule

// File: bher_recovery_test.sv
// Self-checking testbench for the beacon hard-error recovery controller
`timescale 1ns/1ps
`include "bher_params.svh"

module bher_recovery_test;
    localparam logic [33:0] CONT = 34'h64;   // Shortened contention watchdog
    localparam logic [33:0] BRPT = 34'h32;   // Shortened beacon repeat silence
    localparam logic [33:0] BTX  = 34'h12C;  // Shortened self-removal time
    logic                 clk_sys, arst_n, ring_clk, ring_data, run, stuck;
    logic                 claim_rx, purge_rx, bcn_rx, bcn_rx_own, names_me, stream_err;
    logic                 claim_stream, cont_start, cont_won, test_done, test_pass;
    logic [15:0]          bcn_rx_code;       // Code of the foreign beacon
    logic [47:0]          upstream_neighbour_addr;               // Stored neighbour address
    logic                 tx_idle, burst5, sig_loss, purge_act, bcn_send, inserted, test_run, removed_rpt;
    bher_pkg::bher_mode_t mode;              // Observed recovery mode
    logic [15:0]          bcn_code;          // Beacon code sent
    logic [47:0]          bcn_una;           // Neighbour address sent
    int                   mismatches, total_checks, cycles;

    bher_ring_model bher_ring_model_i (.run(run), .stuck(stuck), .ring_clk(ring_clk), .ring_data(ring_data));

    bher_recovery #(.CONT_CYC(CONT), .BRPT_CYC(BRPT), .BTX_CYC(BTX)) bher_recovery_i (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .RING_CLK(ring_clk), .RING_DATA(ring_data),
        .CLAIM_RX(claim_rx), .PURGE_RX(purge_rx), .BCN_RX(bcn_rx), .BCN_RX_OWN(bcn_rx_own),
        .BCN_RX_CODE(bcn_rx_code), .BCN_RX_NAMES_ME(names_me), .STREAM_ERR(stream_err),
        .CLAIM_STREAM(claim_stream), .CONT_START(cont_start), .CONT_WON(cont_won),
        .TEST_DONE(test_done), .TEST_PASS(test_pass), .UPSTREAM_NEIGHBOUR_ADDR(upstream_neighbour_addr),
        .TX_IDLE(tx_idle), .BURST5(burst5), .SIG_LOSS(sig_loss), .PURGE_ACT(purge_act), .MODE(mode),
        .BCN_SEND(bcn_send), .BCN_CODE(bcn_code), .BCN_UNA(bcn_una), .INSERTED(inserted),
        .TEST_RUN(test_run), .REMOVED_RPT(removed_rpt));

    // System clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Watchdog on the whole run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // Step to just after the next rising edge
    task tick;
        @(posedge clk_sys);
        #1;
    endtask

    task stay(input int n);
        repeat (n) tick();
    endtask

    // Compare and count
    task chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_mode(input bher_pkg::bher_mode_t m);
        chk(48'(mode), 48'(m));
    endtask

    // One-cycle event pulse, taken at the next edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    // Reset held two cycles, then idle state checked
    task do_reset;
        arst_n = 1'b0;
        stuck  = 1'b0;
        stay(2);
        arst_n = 1'b1;
        tick();
        chk_mode(bher_pkg::BHER_NORMAL);
        chk(48'(inserted), 48'h1);
        chk(48'(removed_rpt), 48'h0);
    endtask

    // Ring goes silent: idles, burst-5, signal loss, contention, beacon 0002, own beacon back
    task t_sigloss;
        int n, t4, t5, tl;
        n = 0; t4 = 0; t5 = 0; tl = 0;
        do_reset();
        purge_rx = 1'b1;
        tick();
        chk(48'(purge_act), 48'h1);
        purge_rx = 1'b0;
        stay(20);
        chk(48'(tx_idle), 48'h0);
        stuck = 1'b1;
        while (mode !== bher_pkg::BHER_CONT_TX && n < 400) begin
            tick();
            n++;
            if (tx_idle === 1'b1 && t4 == 0) t4 = n;
            if (burst5 === 1'b1 && t5 == 0) t5 = n;
            if (sig_loss === 1'b1 && tl == 0) tl = n;
        end
        chk_mode(bher_pkg::BHER_CONT_TX);
        chk(48'(t4 > 0 && (t5 - t4) >= 3 && (t5 - t4) <= 5), 48'h1);
        chk(48'((tl - t5) >= 104 && (tl - t5) <= 112), 48'h1);
        purge_rx = 1'b1;
        tick();
        chk(48'(purge_act), 48'h0);
        purge_rx = 1'b0;
        stay(int'(CONT) - 2);
        chk_mode(bher_pkg::BHER_CONT_TX);
        tick();
        chk_mode(bher_pkg::BHER_BCN_TX);
        chk(48'(bcn_code), 48'(`BHER_CODE_SIGLOSS));
        stuck = 1'b0;
        stay(40);
        chk(48'(bcn_send), 48'h1);
        pulse(bcn_rx_own);
        chk(48'(mode == bher_pkg::BHER_CONT_TX || mode == bher_pkg::BHER_CONT_RPT), 48'h1);
    endtask

    // Contention timeouts without signal loss give 0003, or 0004 after a claim
    task t_timeout_codes;
        do_reset();
        pulse(cont_start);
        stay(int'(CONT));
        chk_mode(bher_pkg::BHER_BCN_TX);
        chk(48'(bcn_code), 48'(`BHER_CODE_STREAM));
        do_reset();
        pulse(claim_rx);
        chk(48'(mode == bher_pkg::BHER_CONT_TX || mode == bher_pkg::BHER_CONT_RPT), 48'h1);
        stay(int'(CONT));
        chk(48'(bcn_code), 48'(`BHER_CODE_CLAIM));
    endtask

    // Beacon ends contention; repeat times out only after a silent interval
    task t_repeat_timer;
        do_reset();
        pulse(cont_start);
        bcn_rx_code = `BHER_CODE_SIGLOSS;
        pulse(bcn_rx);
        chk_mode(bher_pkg::BHER_BCN_RPT);
        stay(30);
        pulse(bcn_rx);
        stay(int'(BRPT) - 1);
        chk_mode(bher_pkg::BHER_BCN_RPT);
        tick();
        chk(48'(mode == bher_pkg::BHER_CONT_TX || mode == bher_pkg::BHER_CONT_RPT), 48'h1);
        pulse(cont_won);
        chk_mode(bher_pkg::BHER_NORMAL);
    endtask

    // Streaming causes and yielding to foreign beacons
    task t_yield;
        do_reset();
        pulse(stream_err);
        chk_mode(bher_pkg::BHER_BCN_TX);
        chk(48'(bcn_code), 48'(`BHER_CODE_STREAM));
        chk(bcn_una, upstream_neighbour_addr);
        bcn_rx_code = `BHER_CODE_CLAIM;
        pulse(bcn_rx);
        chk_mode(bher_pkg::BHER_BCN_TX);
        tick();
        bcn_rx_code = `BHER_CODE_SIGLOSS;
        pulse(bcn_rx);
        chk_mode(bher_pkg::BHER_BCN_RPT);
        do_reset();
        pulse(claim_stream);
        chk(48'(bcn_code), 48'(`BHER_CODE_CLAIM));
        chk(bcn_una, upstream_neighbour_addr);
        bcn_rx_code = `BHER_CODE_CLAIM;
        pulse(bcn_rx);
        chk_mode(bher_pkg::BHER_BCN_RPT);
    endtask

    // Self-removal after long beaconing, named removal, failed test
    task t_remove;
        do_reset();
        pulse(stream_err);
        stay(int'(BTX) - 1);
        chk_mode(bher_pkg::BHER_BCN_TX);
        tick();
        chk_mode(bher_pkg::BHER_REMOVE);
        chk(48'({inserted, test_run}), 48'h1);
        test_pass = 1'b1;
        pulse(test_done);
        chk_mode(bher_pkg::BHER_NORMAL);
        chk(48'(inserted), 48'h1);
        names_me = 1'b1;
        pulse(bcn_rx);
        names_me = 1'b0;
        chk_mode(bher_pkg::BHER_REMOVE);
        test_pass = 1'b0;
        pulse(test_done);
        chk_mode(bher_pkg::BHER_CLOSED);
        chk(48'({inserted, removed_rpt}), 48'h1);
        pulse(cont_start);
        chk_mode(bher_pkg::BHER_CLOSED);
    endtask

    // Counts, verdict and end of run
    task conclude;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {arst_n, claim_rx, purge_rx, bcn_rx, bcn_rx_own, names_me, stream_err} = 7'h00;
        {claim_stream, cont_start, cont_won, test_done, test_pass, stuck} = 6'h00;
        run          = 1'b1;
        bcn_rx_code  = 16'h0000;
        upstream_neighbour_addr          = 48'hA1B2C3D4E5F6;
        mismatches   = 0;
        total_checks = 0;
        cycles       = 0;
        t_sigloss();
        t_timeout_codes();
        t_repeat_timer();
        t_yield();
        t_remove();
        conclude();
    end
endmodule
